/* File: rvc_consts.svh */
// Constants for the reset and vector control block
// Assumes ref_clk at 50 MHz; included by bare name
`ifndef RVC_CONSTS_SVH
`define RVC_CONSTS_SVH
`define RVC_OFS_SP_LOW 6'h3d
`define RVC_OFS_SP_HIGH 6'h3e
`define RVC_SP_RESET 10'h000
`define RVC_VEC_RESET 10'h000
`define RVC_VEC_FIRST_IRQ 10'h001
`define RVC_CLK_MHZ 50
`define RVC_CRYSTAL_CYCLE_MIN_CYC 3
`define RVC_TOUT_SLOW_US 16000
`define RVC_TOUT_FAST_US 1100
`define RVC_WDOSC_KHZ 1000
`define RVC_TOUT_SLOW_TICKS (`RVC_TOUT_SLOW_US * `RVC_WDOSC_KHZ / 1000)
`define RVC_TOUT_FAST_TICKS (`RVC_TOUT_FAST_US * `RVC_WDOSC_KHZ / 1000)
`endif

/* File: rvc_pkg.sv */
// Types for the reset and vector control block
// Used with rvc_consts.svh
package rvc_pkg;
  typedef struct packed {
    logic push_byte;
    logic pop_byte;
    logic push_addr;
    logic pop_addr;
  } rvc_stack_op_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } rvc_io_req_t;
  typedef enum logic [1:0] {RVC_ST_HOLD, RVC_ST_DELAY, RVC_ST_RUN} rvc_rst_state_t;
endpackage : rvc_pkg

/* File: rvc_delay_timer.sv */
// Start-up delay counter, ticked by the watchdog oscillator
// Assumes osc_tick is already synchronised to ref_clk
`timescale 1ns/1ns
`include "rvc_consts.svh"
module rvc_delay_timer #(
  parameter int SLOW_TICKS = `RVC_TOUT_SLOW_TICKS,
  parameter int FAST_TICKS = `RVC_TOUT_FAST_TICKS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic restart,
  input wire logic osc_tick,
  input wire logic fast_start_fuse,
  output logic expired
);
  initial begin
    if (SLOW_TICKS < 1 || FAST_TICKS < 1 || SLOW_TICKS > 65535 || FAST_TICKS > 65535) begin
      $error("rvc_delay_timer: tick counts out of range");
    end
  end
  logic [15:0] cnt_q;
  wire [15:0] limit = fast_start_fuse ? 16'(FAST_TICKS) : 16'(SLOW_TICKS);
  wire done = (cnt_q >= limit);
  always_ff @(posedge ref_clk) begin
    if (rst || restart) begin
      cnt_q <= 16'h0000;
    end else if (osc_tick && !done) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
  assign expired = done && !restart;
endmodule : rvc_delay_timer

/* File: rvc_reset_vector.sv */
// Reset collection, interrupt vectoring and stack pointer
// Assumes the core raises stack operations and instruction boundaries as pulses
`timescale 1ns/1ns
`include "rvc_consts.svh"
// What this block does
// - Stack pointer is two bytes, ten bits
// - Byte push lowers pointer by one
// - Call or interrupt lowers pointer by two
// - Byte pop raises pointer by one
// - Return raises pointer by two
// - Sixteen sources, each own vector
// - Take only if source and global enabled
// - Lowest vector wins; reset ranks first
// - Reset 000, request zero 001, one 002
// - Timer vectors sit at 003 to 009
// - Remaining vectors 00A through 010
// - Vector 000 serves pin and watchdog
// - Pin low over two cycles resets
// - Enabled watchdog expiry resets
// - Reset clears registers, fetch from 000
// - Unused vectors free for program code
// - Core held for oscillator-timed delay
// - Fuse picks 16 ms or 1.1 ms
// - Low pin extends power-on reset
// - Taking interrupt clears global enable
// - Vectoring clears the source flag
// - Watchdog pulse one cycle, delay after
module rvc_reset_vector #(
  parameter int NUM_IRQ = 16,
  parameter int SLOW_TICKS = `RVC_TOUT_SLOW_TICKS,
  parameter int FAST_TICKS = `RVC_TOUT_FAST_TICKS
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic reset_pin_n,
  input wire logic wdt_osc_tick,
  input wire logic wdt_enable,
  input wire logic wdt_expire,
  input wire logic fast_start_fuse,
  input wire logic [NUM_IRQ-1:0] irq_pending,
  input wire logic [NUM_IRQ-1:0] irq_enable,
  input wire logic global_ie,
  input wire logic insn_boundary,
  input wire rvc_pkg::rvc_stack_op_t stack_op,
  input wire rvc_pkg::rvc_io_req_t io_req,
  output logic [7:0] io_rdata,
  output logic core_reset,
  output logic irq_take,
  output logic [9:0] vector_addr,
  output logic [NUM_IRQ-1:0] irq_ack,
  output logic global_ie_clear,
  output logic [9:0] stack_pointer,
  output logic [3:0] reset_cause
);
  initial begin
    if (NUM_IRQ != 16) begin
      $error("rvc_reset_vector: vector table holds exactly sixteen sources");
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; the first stage feeds only the second
  logic pin_s1_q;
  logic pin_s2_q;
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  always_ff @(posedge ref_clk) begin
    pin_s1_q <= reset_pin_n;
    pin_s2_q <= pin_s1_q;
    osc_s1_q <= wdt_osc_tick;
    osc_s2_q <= osc_s1_q;
    osc_s3_q <= osc_s2_q;
  end
  wire osc_edge = osc_s2_q && !osc_s3_q;

  ////////////////////////////////////////////////////////////////////////
  // Reset sources
  logic [1:0] low_cnt_q;
  logic wdt_pulse_q;
  wire pin_low = !pin_s2_q;
  // Filter: low must persist beyond two cycles, so glitches do not reset
  wire pin_reset = pin_low && (low_cnt_q == 2'(`RVC_CRYSTAL_CYCLE_MIN_CYC - 1));
  wire wdt_fire = wdt_enable && wdt_expire;
  always_ff @(posedge ref_clk) begin
    if (rst || !pin_low) begin
      low_cnt_q <= 2'h0;
    end else if (low_cnt_q != 2'(`RVC_CRYSTAL_CYCLE_MIN_CYC - 1)) begin
      low_cnt_q <= low_cnt_q + 2'h1;
    end
  end
  always_ff @(posedge ref_clk) begin
    wdt_pulse_q <= !rst && wdt_fire && !wdt_pulse_q;
  end

  rvc_pkg::rvc_rst_state_t st_q;
  rvc_pkg::rvc_rst_state_t st_d;
  logic [3:0] cause_q;
  logic [3:0] cause_d;
  // Held clear outside DELAY, so a watchdog reset times a full delay again
  wire delay_restart = (st_q != rvc_pkg::RVC_ST_DELAY);
  wire delay_done;
  rvc_delay_timer #(
    .SLOW_TICKS(SLOW_TICKS),
    .FAST_TICKS(FAST_TICKS)
  ) u_delay (
    .ref_clk(ref_clk),
    .rst(rst),
    .restart(delay_restart),
    .osc_tick(osc_edge),
    .fast_start_fuse(fast_start_fuse),
    .expired(delay_done)
  );

  always_comb begin
    st_d = st_q;
    cause_d = cause_q;
    unique case (st_q)
      rvc_pkg::RVC_ST_HOLD: begin
        // Pin held low keeps the core in reset, extending power-on
        if (!pin_low) st_d = rvc_pkg::RVC_ST_DELAY;
      end
      rvc_pkg::RVC_ST_DELAY: begin
        if (pin_reset) st_d = rvc_pkg::RVC_ST_HOLD;
        else if (delay_done) st_d = rvc_pkg::RVC_ST_RUN;
      end
      rvc_pkg::RVC_ST_RUN: begin
        if (pin_reset) begin
          st_d = rvc_pkg::RVC_ST_HOLD;
          cause_d = cause_q | 4'h2;
        end else if (wdt_pulse_q) begin
          // Delay counts from the end of the one-cycle pulse
          st_d = rvc_pkg::RVC_ST_DELAY;
          cause_d = cause_q | 4'h4;
        end
      end
    endcase
  end
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= rvc_pkg::RVC_ST_HOLD;
      cause_q <= 4'h1;
    end else begin
      st_q <= st_d;
      cause_q <= cause_d;
    end
  end
  wire in_reset = (st_q != rvc_pkg::RVC_ST_RUN);

  ////////////////////////////////////////////////////////////////////////
  // Interrupt selection: bit i maps to vector i+1, lowest index wins
  wire [NUM_IRQ-1:0] irq_live = irq_pending & irq_enable & {NUM_IRQ{global_ie}};
  logic [NUM_IRQ-1:0] lower_live;
  logic [NUM_IRQ-1:0] grant;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_IRQ; gi++) begin : g_prio
      if (gi == 0) begin : g_first
        assign lower_live[gi] = 1'b0;
      end else begin : g_rest
        assign lower_live[gi] = lower_live[gi-1] | irq_live[gi-1];
      end
      assign grant[gi] = irq_live[gi] & ~lower_live[gi];
    end
  endgenerate
  logic [9:0] grant_vec;
  always_comb begin
    grant_vec = `RVC_VEC_RESET;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (grant[i]) grant_vec = `RVC_VEC_FIRST_IRQ + 10'(i);
    end
  end
  // With nothing enabled no vector is ever emitted, so that code space is free
  wire take = !in_reset && insn_boundary && (|grant);

  logic take_q;
  logic core_reset_q;
  logic [9:0] vec_q;
  logic [NUM_IRQ-1:0] ack_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      take_q <= 1'b0;
      core_reset_q <= 1'b1;
      vec_q <= `RVC_VEC_RESET;
      ack_q <= '0;
    end else begin
      take_q <= take;
      core_reset_q <= in_reset;
      ack_q <= take ? grant : '0;
      if (in_reset) vec_q <= `RVC_VEC_RESET;
      else if (take) vec_q <= grant_vec;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stack pointer and its two I/O bytes
  logic [9:0] sp_q;
  logic [9:0] sp_d;
  logic [7:0] rdata_q;
  wire wr_low = io_req.wr && (io_req.addr == `RVC_OFS_SP_LOW);
  wire wr_high = io_req.wr && (io_req.addr == `RVC_OFS_SP_HIGH);
  // Interrupt entry stacks the return address like a call
  wire dec2 = stack_op.push_addr || take;
  always_comb begin
    sp_d = sp_q;
    if (wr_low) sp_d[7:0] = io_req.wdata;
    else if (wr_high) sp_d[9:8] = io_req.wdata[1:0];
    else if (dec2) sp_d = sp_q - 10'h002;
    else if (stack_op.pop_addr) sp_d = sp_q + 10'h002;
    else if (stack_op.push_byte) sp_d = sp_q - 10'h001;
    else if (stack_op.pop_byte) sp_d = sp_q + 10'h001;
  end
  wire [7:0] rd_mux = (io_req.addr == `RVC_OFS_SP_LOW) ? sp_q[7:0] :
                      (io_req.addr == `RVC_OFS_SP_HIGH) ? {6'h00, sp_q[9:8]} : 8'h00;
  always_ff @(posedge ref_clk) begin
    if (rst || in_reset) begin
      sp_q <= `RVC_SP_RESET;
      rdata_q <= 8'h00;
    end else begin
      sp_q <= sp_d;
      rdata_q <= io_req.rd ? rd_mux : 8'h00;
    end
  end

  assign io_rdata = rdata_q;
  assign core_reset = core_reset_q;
  assign irq_take = take_q;
  assign vector_addr = vec_q;
  assign irq_ack = ack_q;
  assign global_ie_clear = take_q;
  assign stack_pointer = sp_q;
  assign reset_cause = cause_q;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  property p_push_byte;
    @(posedge ref_clk) disable iff (rst)
    (!in_reset && stack_op == 4'b1000 && !take && !io_req.wr) |=> (sp_q == $past(sp_q) - 10'h001);
  endproperty
  a_push_byte: assert property (p_push_byte) else $error("byte push not minus one");
  property p_pop_byte;
    @(posedge ref_clk) disable iff (rst)
    (!in_reset && stack_op == 4'b0100 && !take && !io_req.wr) |=> (sp_q == $past(sp_q) + 10'h001);
  endproperty
  a_pop_byte: assert property (p_pop_byte) else $error("byte pop not plus one");
  property p_call;
    @(posedge ref_clk) disable iff (rst)
    (!in_reset && stack_op == 4'b0010 && !io_req.wr) |=> (sp_q == $past(sp_q) - 10'h002);
  endproperty
  a_call: assert property (p_call) else $error("call not minus two");
  property p_ret;
    @(posedge ref_clk) disable iff (rst)
    (!in_reset && stack_op == 4'b0001 && !take && !io_req.wr) |=> (sp_q == $past(sp_q) + 10'h002);
  endproperty
  a_ret: assert property (p_ret) else $error("return not plus two");
  property p_enable_gate;
    @(posedge ref_clk) disable iff (rst)
    irq_take |-> $past(global_ie);
  endproperty
  a_enable_gate: assert property (p_enable_gate) else $error("interrupt taken while disabled");
  property p_ie_clear;
    @(posedge ref_clk) disable iff (rst)
    irq_take |-> global_ie_clear && $onehot(irq_ack);
  endproperty
  a_ie_clear: assert property (p_ie_clear) else $error("entry did not clear enable or ack");
  property p_vec_ack;
    @(posedge ref_clk) disable iff (rst)
    irq_take |-> (irq_ack == (16'h0001 << (vector_addr - 10'h001)));
  endproperty
  a_vec_ack: assert property (p_vec_ack) else $error("vector and flag clear disagree");
  property p_reset_vec;
    @(posedge ref_clk) disable iff (rst)
    core_reset |-> ##1 (vector_addr == 10'h000) && (stack_pointer == 10'h000);
  endproperty
  a_reset_vec: assert property (p_reset_vec) else $error("reset did not restore vector");
  property p_pin_reset;
    @(posedge ref_clk) disable iff (rst)
    (!pin_s2_q)[*4] |-> ##[1:2] core_reset;
  endproperty
  a_pin_reset: assert property (p_pin_reset) else $error("held pin did not reset");
  property p_wdt_delay;
    @(posedge ref_clk) disable iff (rst)
    (st_q == rvc_pkg::RVC_ST_RUN && wdt_pulse_q && !pin_reset) |=>
      (st_q == rvc_pkg::RVC_ST_DELAY) && !delay_done;
  endproperty
  a_wdt_delay: assert property (p_wdt_delay) else $error("watchdog skipped delay");
  property p_wdt_pulse;
    @(posedge ref_clk) disable iff (rst)
    wdt_pulse_q |=> !wdt_pulse_q;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse) else $error("watchdog pulse too long");
  property p_priority;
    @(posedge ref_clk) disable iff (rst)
    irq_take |-> (((irq_ack - 16'h0001) & $past(irq_pending & irq_enable)) == 16'h0000);
  endproperty
  a_priority: assert property (p_priority) else $error("lower vector was waiting");
  property p_boundary;
    @(posedge ref_clk) disable iff (rst)
    irq_take |-> $past(insn_boundary);
  endproperty
  a_boundary: assert property (p_boundary) else $error("entry off a boundary");
  property p_pin_extend;
    @(posedge ref_clk) disable iff (rst)
    (st_q == rvc_pkg::RVC_ST_HOLD && pin_low) |=>
      (st_q == rvc_pkg::RVC_ST_HOLD) && core_reset;
  endproperty
  a_pin_extend: assert property (p_pin_extend) else $error("low pin did not hold reset");
endmodule : rvc_reset_vector

/* File: rvc_core_model.sv */
// Core and peripheral stand-in: request flags, global enable, watchdog oscillator
// Assumes the bench pulses raise_flags and set_ie for one ref_clk cycle
`timescale 1ns/1ns
module rvc_core_model (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [15:0] raise_flags,
  input wire logic set_ie,
  input wire logic [15:0] irq_ack,
  input wire logic global_ie_clear,
  output logic [15:0] irq_pending,
  output logic global_ie,
  output logic wdt_osc_tick
);
  ////////////////////////////////////////
  // Free running, period 23 ref_clk cycles, so its phase to ref_clk is fixed
  initial begin
    wdt_osc_tick = 1'b0;
    forever #230 wdt_osc_tick = ~wdt_osc_tick;
  end
  ////////////////////////////////////////
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      irq_pending <= 16'h0000;
      global_ie <= 1'b0;
    end else begin
      irq_pending <= (irq_pending & ~irq_ack) | raise_flags;
      global_ie <= set_ie | (global_ie & ~global_ie_clear);
    end
  end
endmodule : rvc_core_model

/* File: rvc_reset_vector_tb.sv */
// Self-checking bench for the reset and vector block
// Assumes delay counts shortened to 4 and 2 oscillator edges
`timescale 1ns/1ns
module rvc_reset_vector_tb;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic reset_pin_n = 1'b1;
  logic wdt_enable = 1'b0;
  logic wdt_expire = 1'b0;
  logic fast_start_fuse = 1'b0;
  logic [15:0] irq_enable = 16'h0000;
  logic [15:0] raise = 16'h0000;
  logic set_ie = 1'b0;
  logic insn_boundary = 1'b0;
  rvc_pkg::rvc_stack_op_t stack_op = '0;
  rvc_pkg::rvc_io_req_t io_req = '0;
  logic [15:0] irq_pending, irq_ack;
  logic global_ie, wdt_osc_tick, core_reset, irq_take, global_ie_clear;
  logic [7:0] io_rdata;
  logic [9:0] vector_addr, stack_pointer, sp_exp;
  logic [3:0] reset_cause;
  int error_cnt = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_slow, n_fast;
  always #10 ref_clk = ~ref_clk;
  rvc_reset_vector #(.SLOW_TICKS(4), .FAST_TICKS(2)) u_dut (.ref_clk(ref_clk), .rst(rst),
    .reset_pin_n(reset_pin_n), .wdt_osc_tick(wdt_osc_tick), .wdt_enable(wdt_enable),
    .wdt_expire(wdt_expire), .fast_start_fuse(fast_start_fuse), .irq_pending(irq_pending),
    .irq_enable(irq_enable), .global_ie(global_ie), .insn_boundary(insn_boundary),
    .stack_op(stack_op), .io_req(io_req), .io_rdata(io_rdata), .core_reset(core_reset),
    .irq_take(irq_take), .vector_addr(vector_addr), .irq_ack(irq_ack),
    .global_ie_clear(global_ie_clear), .stack_pointer(stack_pointer),
    .reset_cause(reset_cause));
  // Clearing on core reset too, as peripherals return to initial values
  rvc_core_model u_core (.ref_clk(ref_clk), .rst(rst | core_reset), .raise_flags(raise),
    .set_ie(set_ie), .irq_ack(irq_ack), .global_ie_clear(global_ie_clear),
    .irq_pending(irq_pending), .global_ie(global_ie), .wdt_osc_tick(wdt_osc_tick));
  ////////////////////////////////////////
  task automatic report_and_stop();
    $display("errors=%0d checks=%0d", error_cnt, samples_checked);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  // Whole run is well under a thousand cycles; ceiling leaves wide margin
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  task automatic io(input logic w, input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk) io_req <= {w, ~w, a, d};
    @(posedge ref_clk) io_req <= '0;
    #1;
  endtask : io
  task automatic sop(input logic [3:0] op, input logic [9:0] d);
    @(posedge ref_clk) stack_op <= op;
    @(posedge ref_clk) stack_op <= '0;
    #1;
    sp_exp = sp_exp + d;
    chk(stack_pointer, sp_exp);
  endtask : sop
  task automatic wait_run(output int n);
    for (n = 0; n < 3000 && core_reset !== 1'b0; n++) begin
      @(posedge ref_clk);
      #1;
    end
    chk(core_reset, 16'h0000);
  endtask : wait_run
  task automatic irq(input logic [15:0] r, input logic ie, input logic [15:0] en,
    input logic [9:0] v);
    @(posedge ref_clk) begin
      raise <= r;
      set_ie <= ie;
      irq_enable <= en;
    end
    @(posedge ref_clk) begin
      raise <= '0;
      set_ie <= 1'b0;
      insn_boundary <= 1'b1;
    end
    @(posedge ref_clk) insn_boundary <= 1'b0;
    #1;
    chk(irq_take, v != 10'h000);
    if (v != 10'h000) begin
      sp_exp = sp_exp - 10'h002;
      chk(vector_addr, v);
      chk(irq_ack, 16'h0001 << (v - 10'h001));
      chk(global_ie_clear, 1);
      chk(stack_pointer, sp_exp);
    end
    @(posedge ref_clk);
    #1;
    chk(irq_take, 0);
  endtask : irq
  task automatic pin_reset(input logic f, output int n);
    @(posedge ref_clk) begin
      reset_pin_n <= 1'b0;
      fast_start_fuse <= f;
    end
    repeat (8) @(posedge ref_clk);
    #1;
    chk(core_reset, 1);
    repeat (40) @(posedge ref_clk);
    #1;
    chk(core_reset, 1);
    chk(vector_addr, 0);
    chk(stack_pointer, 0);
    @(posedge ref_clk) reset_pin_n <= 1'b1;
    wait_run(n);
    sp_exp = 10'h000;
  endtask : pin_reset
  task automatic wdt(input logic en);
    @(posedge ref_clk) begin
      wdt_enable <= en;
      wdt_expire <= 1'b1;
    end
    @(posedge ref_clk) wdt_expire <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : wdt
  ////////////////////////////////////////
  initial begin
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    wait_run(n_slow);
    chk(vector_addr, 0);
    chk(stack_pointer, 0);
    chk(reset_cause, 16'h0001);
    io(1'b1, 6'h3E, 8'hFF);
    io(1'b1, 6'h3D, 8'h5A);
    sp_exp = 10'h35A;
    chk(stack_pointer, sp_exp);
    io(1'b0, 6'h3E, 8'h00);
    chk(io_rdata, 8'h03);
    io(1'b0, 6'h3D, 8'h00);
    chk(io_rdata, 8'h5A);
    io(1'b0, 6'h3F, 8'h00);
    chk(io_rdata, 8'h00);
    sop(4'b1000, 10'h3FF);
    sop(4'b0010, 10'h3FE);
    sop(4'b0100, 10'h001);
    sop(4'b0001, 10'h002);
    for (int i = 0; i < 16; i++) begin
      irq(16'h8000 | (16'h0001 << i), 1'b1, 16'hFFFF, 10'(i + 1));
    end
    irq(16'h0002, 1'b0, 16'hFFFF, 10'h000);
    irq(16'h0000, 1'b1, 16'hFFFD, 10'h000);
    irq(16'h0000, 1'b0, 16'hFFFF, 10'h002);
    @(posedge ref_clk) reset_pin_n <= 1'b0;
    @(posedge ref_clk);
    @(posedge ref_clk) reset_pin_n <= 1'b1;
    repeat (10) @(posedge ref_clk);
    #1;
    chk(core_reset, 0);
    pin_reset(1'b0, n_slow);
    chk(reset_cause, 16'h0003);
    pin_reset(1'b1, n_fast);
    chk(n_fast < n_slow, 1);
    wdt(1'b0);
    chk(core_reset, 0);
    wdt(1'b1);
    chk(core_reset, 1);
    chk(vector_addr, 0);
    chk(reset_cause, 16'h0007);
    wait_run(n_fast);
    chk(core_reset, 0);
    report_and_stop();
  end
endmodule : rvc_reset_vector_tb
